/* File: rtl/sar_adc_convert_readout_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Rising start edge begins a conversion; running conversion never restarts.
// - Conversion timed by internal clock count, within maximum, independent of serial clock.
// - Acquisition of at least minimum time precedes each conversion; host spaces starts. Code also accepts a start in idle, with no acquisition.
// - Host lowers start after conversion; output driver enabled only while start low.
// - Bipolar gives two's complement, unipolar gives straight binary.
// - Start low at completion puts MSB out immediately and stays powered.
// - Positive and negative inputs sampled by one shared sample strobe.
// - Sampler connected once per cycle during acquisition, disconnected in conversion.
// - Two-input variant selects single-ended or differential; one-input always differential.
// - First six rising serial-clock edges capture configuration word in order.
// - Serial output changes on each of the first twelve falling serial-clock edges after completion.
// - Bit one single/differential, bit two odd/sign, bit five unipolar.
// - Start high after conversion time puts device into sleep; wakes when low.
module sar_adc_convert_readout_ctrl #(
  parameter int NUM_INPUTS = 2,
  parameter int CONV_CNT = sar_adc_pkg::CONV_CYCLES,
  parameter int ACQ_CNT = sar_adc_pkg::ACQ_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host serial port
  input wire logic conversion_start_pin,
  input wire logic serialClk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // Analog front end control
  output logic sampleConnect,
  output logic sampleHold,
  output logic analog_input_zero_pos,
  output logic analog_input_zero_neg,
  output logic analog_input_one_pos,
  output logic analog_input_one_neg,
  output logic singleEnded,
  output logic bitTrial,
  output logic [3:0] bitIndex,
  input wire logic compareHigh,
  output logic poweredUp,
  // Result stream
  output logic resultValid,
  input wire logic resultReady,
  output logic [11:0] resultData
);

  initial begin
    if (NUM_INPUTS != 1 && NUM_INPUTS != 2) $error("NUM_INPUTS must be 1 or 2");
    if (CONV_CNT < sar_adc_pkg::RESULT_BITS || CONV_CNT > sar_adc_pkg::CONV_MAX_CYCLES) $error("CONV_CNT out of range");
    if (ACQ_CNT < sar_adc_pkg::ACQ_CYCLES) $error("ACQ_CNT too short");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] startSync_ff;
  logic [1:0] sckSync_ff;
  logic [1:0] sdiSync_ff;
  logic startPrev_ff;
  logic sckPrev_ff;
  logic startLvl;
  logic sckRise;
  logic sckFall;
  logic startRise;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      startSync_ff <= 2'h0;
      sckSync_ff <= 2'h0;
      sdiSync_ff <= 2'h0;
      startPrev_ff <= 1'b0;
      sckPrev_ff <= 1'b0;
    end else begin
      startSync_ff <= {startSync_ff[0], conversion_start_pin};
      sckSync_ff <= {sckSync_ff[0], serialClk};
      sdiSync_ff <= {sdiSync_ff[0], serialIn};
      startPrev_ff <= startSync_ff[1];
      sckPrev_ff <= sckSync_ff[1];
    end
  end

  assign startLvl = startSync_ff[1];
  assign startRise = startLvl && !startPrev_ff;
  assign sckRise = sckSync_ff[1] && !sckPrev_ff;
  assign sckFall = !sckSync_ff[1] && sckPrev_ff;

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  sar_adc_pkg::conv_state_type state_ff;
  logic [4:0] cnt_ff;
  logic [11:0] sar_ff;
  logic [11:0] trial;
  logic convDone;
  logic [5:0] cfg_ff;
  logic [5:0] cfgActive_ff;
  logic [2:0] cfgCnt_ff;
  logic [3:0] outCnt_ff;
  logic [11:0] shift_ff;
  logic startAccepted;
  logic bufInReady;
  logic [11:0] coded;

  assign startAccepted = startRise && (state_ff == sar_adc_pkg::ST_ACQUIRE || state_ff == sar_adc_pkg::ST_IDLE);
  assign convDone = (state_ff == sar_adc_pkg::ST_CONVERT) && (cnt_ff == 5'(CONV_CNT - 1));

  // Result coding selected by the captured unipolar bit
  function automatic logic [11:0] code_result(input logic [11:0] raw, input logic unipolar_select_bit);
    code_result = unipolar_select_bit ? raw : (raw ^ sar_adc_pkg::MIDSCALE);
  endfunction

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= sar_adc_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        sar_adc_pkg::ST_ACQUIRE, sar_adc_pkg::ST_IDLE: begin
          if (state_ff == sar_adc_pkg::ST_ACQUIRE && cnt_ff != 5'(ACQ_CNT)) begin
            cnt_ff <= cnt_ff + 5'h01;
          end
          if (startAccepted) begin
            state_ff <= sar_adc_pkg::ST_CONVERT;
            cnt_ff <= 5'h00;
          end
        end
        sar_adc_pkg::ST_CONVERT: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (convDone) begin
            cnt_ff <= 5'h00;
            state_ff <= startLvl ? sar_adc_pkg::ST_SLEEP : sar_adc_pkg::ST_IDLE;
          end
        end
        sar_adc_pkg::ST_SLEEP: begin
          if (!startLvl) begin
            state_ff <= sar_adc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= sar_adc_pkg::ST_IDLE;
          cnt_ff <= 5'h00;
        end
      endcase
      // Acquisition opens after the configuration word is in
      if (state_ff == sar_adc_pkg::ST_IDLE && cfgCnt_ff == 3'(sar_adc_pkg::CFG_BITS) && !startAccepted) begin
        state_ff <= sar_adc_pkg::ST_ACQUIRE;
        cnt_ff <= 5'h00;
      end
    end
  end

  // SAR decisions, MSB first, one per cycle
  assign trial = sar_ff | (sar_adc_pkg::MIDSCALE >> cnt_ff[3:0]);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sar_ff <= 12'h000;
    end else if (startAccepted) begin
      sar_ff <= 12'h000;
    end else if (state_ff == sar_adc_pkg::ST_CONVERT && cnt_ff < 5'(sar_adc_pkg::RESULT_BITS)) begin
      sar_ff <= compareHigh ? sar_ff : trial;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bitTrial <= 1'b0;
      bitIndex <= 4'h0;
    end else begin
      // Shows the trial that the next decision will judge
      bitTrial <= startAccepted ||
        ((state_ff == sar_adc_pkg::ST_CONVERT) && (cnt_ff < 5'(sar_adc_pkg::RESULT_BITS - 1)));
      bitIndex <= startAccepted ? 4'h0 : (cnt_ff[3:0] + 4'h1);
    end
  end

  // ----------------------------------------
  // Sampler and multiplexer
  // ----------------------------------------
  logic sglSel;
  logic oddSel;
  assign sglSel = (NUM_INPUTS == 2) ? cfgActive_ff[sar_adc_pkg::CFG_SGL_POS] : 1'b0;
  assign oddSel = cfgActive_ff[sar_adc_pkg::CFG_ODD_POS];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sampleConnect <= 1'b0;
      sampleHold <= 1'b0;
      analog_input_zero_pos <= 1'b0;
      analog_input_zero_neg <= 1'b0;
      analog_input_one_pos <= 1'b0;
      analog_input_one_neg <= 1'b0;
      singleEnded <= 1'b0;
      poweredUp <= 1'b1;
    end else begin
      sampleConnect <= (state_ff == sar_adc_pkg::ST_ACQUIRE) && !startAccepted;
      sampleHold <= startAccepted;
      singleEnded <= sglSel;
      analog_input_zero_pos <= !oddSel;
      analog_input_zero_neg <= oddSel && !sglSel;
      analog_input_one_pos <= oddSel;
      analog_input_one_neg <= !oddSel && !sglSel;
      poweredUp <= (state_ff != sar_adc_pkg::ST_SLEEP);
    end
  end

  // ----------------------------------------
  // Configuration capture
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_ff <= sar_adc_pkg::CFG_RESET;
      cfgCnt_ff <= 3'h0;
      cfgActive_ff <= sar_adc_pkg::CFG_RESET;
    end else if (startLvl) begin
      cfgCnt_ff <= 3'h0;
    end else if (sckRise && cfgCnt_ff < 3'(sar_adc_pkg::CFG_BITS)) begin
      cfg_ff <= {cfg_ff[4:0], sdiSync_ff[1]};
      cfgCnt_ff <= cfgCnt_ff + 3'h1;
      if (cfgCnt_ff == 3'(sar_adc_pkg::CFG_BITS - 1)) begin
        cfgActive_ff <= {cfg_ff[4:0], sdiSync_ff[1]};
      end
    end
  end

  // ----------------------------------------
  // Result buffer and serial output
  // ----------------------------------------
  assign coded = code_result(sar_ff, cfgActive_ff[sar_adc_pkg::CFG_UNI_POS]);

  two_entry_buffer #(
    .WIDTH(sar_adc_pkg::RESULT_BITS)
  ) resultBuf (
    .clk(clk),
    .resetn(resetn),
    .inValid(convDone),
    .inReady(bufInReady),
    .inData(coded),
    .outValid(resultValid),
    .outReady(resultReady),
    .outData(resultData)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift_ff <= 12'h000;
      outCnt_ff <= 4'h0;
    end else if (convDone) begin
      shift_ff <= coded;
      outCnt_ff <= 4'h0;
    end else if (!startLvl && sckFall && outCnt_ff != 4'(sar_adc_pkg::RESULT_BITS)) begin
      shift_ff <= {shift_ff[10:0], 1'b0};
      outCnt_ff <= outCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else begin
      serialOut <= shift_ff[11];
      serialOutEn <= !startLvl && (state_ff != sar_adc_pkg::ST_CONVERT);
    end
  end

endmodule
`default_nettype wire

/* File: rtl/sar_adc_pkg.sv */
package sar_adc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_TYP_NS = 1300;
  localparam int CONV_TIME_MAX_NS = 1600;
  localparam int ACQ_TIME_MIN_NS = 240;
  // Typical and longest times round down, at least one cycle
  localparam int CONV_CYCLES = (CONV_TIME_TYP_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_TIME_TYP_NS / CLK_PERIOD_NS);
  localparam int CONV_MAX_CYCLES = (CONV_TIME_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_TIME_MAX_NS / CLK_PERIOD_NS);
  // Least time rounds up
  localparam int ACQ_CYCLES = (ACQ_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Result and configuration word
  // ----------------------------------------
  localparam int RESULT_BITS = 12;
  localparam int CFG_BITS = 6;
  localparam int CFG_SGL_POS = 5;
  localparam int CFG_ODD_POS = 4;
  localparam int CFG_UNI_POS = 1;
  localparam logic [11:0] MIDSCALE = 12'h800;
  localparam logic [5:0] CFG_RESET = 6'h02;

  // ----------------------------------------
  // Converter states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_IDLE = 2'b10,
    ST_SLEEP = 2'b11
  } conv_state_type;

endpackage

/* File: rtl/two_entry_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem_ff [2];
  logic rdPtr_ff;
  logic wrPtr_ff;
  logic [1:0] count_ff;
  logic doWrite;
  logic doRead;

  assign inReady = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData = mem_ff[rdPtr_ff];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdPtr_ff <= 1'b0;
      wrPtr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (doWrite) begin
        wrPtr_ff <= !wrPtr_ff;
      end
      if (doRead) begin
        rdPtr_ff <= !rdPtr_ff;
      end
      count_ff <= count_ff + {1'b0, doWrite} - {1'b0, doRead};
    end
  end

endmodule
`default_nettype wire

/* File: testbench/sar_adc_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial port
  input wire logic conversion_start_pin,
  input wire logic serialClk,
  input wire logic serialOut,
  input wire logic serialOutEn,
  // Front end
  input wire logic sampleConnect,
  input wire logic sampleHold,
  input wire logic analog_input_zero_neg,
  input wire logic analog_input_one_neg,
  input wire logic singleEnded,
  input wire logic bitTrial,
  input wire logic poweredUp,
  // Stream
  input wire logic resultValid,
  input wire logic resultReady,
  input wire logic [11:0] resultData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------
  // Checks
  // ----------------
  a_oe_start_high: assert property (conversion_start_pin [*5] |-> !serialOutEn)
    else $error("output enabled with start high");
  a_trial_disconnect: assert property (bitTrial |-> !sampleConnect)
    else $error("sampler connected in conversion");
  a_hold_single: assert property (sampleHold |=> !sampleHold [*8])
    else $error("second hold in conversion");
  a_conv_bound: assert property ($rose(bitTrial) |-> ##[1:16] !bitTrial)
    else $error("conversion too long");
  a_wake_low: assert property (!conversion_start_pin [*6] |-> poweredUp)
    else $error("asleep with start low");
  a_mux_single: assert property (singleEnded |-> !(analog_input_zero_neg || analog_input_one_neg))
    else $error("negative side set in single-ended");
  a_valid_hold: assert property (resultValid && !resultReady |=> resultValid && $stable(resultData))
    else $error("stream word lost");
  a_out_stable: assert property (serialClk [*4] ##0 serialOutEn && $past(serialOutEn) |-> $stable(serialOut))
    else $error("output changed with clock high");
endmodule
`default_nettype wire

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  // Host pins
  output logic conversion_start_pin,
  output logic serialClk,
  output logic serialIn,
  // Device pins
  input wire logic serialOut,
  input wire logic serialOutEn
);
  initial begin
    conversion_start_pin = 1'b0;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // ----------------
  // Start pulse
  // ----------------
  task automatic start(input int hiNs);
    #137 conversion_start_pin = 1'b1;
    #(hiNs) conversion_start_pin = 1'b0;
  endtask
  // ----------------
  // Frame of 12 pulses
  // ----------------
  task automatic xfer(input logic [5:0] cfg, output logic [11:0] rd);
    // Keep pin edges off the sampling clock edge
    #20;
    for (int i = 0; i < 12; i++) begin
      serialIn = (i < 6) ? cfg[5 - i] : ~serialIn;
      #400 serialClk = 1'b1;
      #400 rd[11 - i] = serialOutEn ? serialOut : ~serialOut;
      serialClk = 1'b0;
    end
    #1000;
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_sar_adc_convert_readout_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_convert_readout_ctrl;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic resultReady = 1'b0;
  logic [11:0] code = 12'h000;
  logic [11:0] rd;
  logic conversion_start_pin, serialClk, serialIn, serialOut, serialOutEn, sampleConnect, sampleHold;
  logic analog_input_zero_pos, analog_input_zero_neg, analog_input_one_pos, analog_input_one_neg;
  logic singleEnded, bitTrial, compareHigh, poweredUp, resultValid;
  logic [3:0] bitIndex;
  logic [11:0] resultData;
  logic [33:0] rows [5] = '{{6'h10, 12'hA5C, 12'hA5C, 4'h6}, {6'h22, 12'h123, 12'h923, 4'h8},
    {6'h30, 12'hFFF, 12'hFFF, 4'h2}, {6'h02, 12'h000, 12'h800, 4'h9}, {6'h0F, 12'h7FF, 12'h7FF, 4'h9}};
  int failures = 0;
  int checks = 0;
  int holds = 0;
  int n;
  always #50 clk = ~clk;
  always @(posedge clk) if (sampleHold) holds <= holds + 1;
  // Comparator of an ideal input at code
  assign compareHigh = (bitIndex < 4'hC) ? !code[4'hB - bitIndex] : 1'b0;
  sar_adc_convert_readout_ctrl sar_adc_convert_readout_ctrl_inst (.clk, .resetn, .conversion_start_pin,
    .serialClk, .serialIn, .serialOut, .serialOutEn, .sampleConnect, .sampleHold, .analog_input_zero_pos,
    .analog_input_zero_neg, .analog_input_one_pos, .analog_input_one_neg, .singleEnded, .bitTrial,
    .bitIndex, .compareHigh, .poweredUp, .resultValid, .resultReady, .resultData);
  spi_host_model host_inst (.conversion_start_pin, .serialClk, .serialIn, .serialOut, .serialOutEn);
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic conv(input logic [5:0] cfg, input logic [11:0] c);
    @(posedge clk) code <= c;
    host_inst.start(250);
    repeat (20) @(posedge clk);
    host_inst.xfer(cfg, rd);
  endtask
  task automatic pop;
    @(posedge clk) resultReady <= 1'b1;
    @(posedge clk) resultReady <= 1'b0;
    @(negedge clk);
  endtask
  initial begin
    #400000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      conv(rows[i][33:28], rows[i][27:16]);
      chk("serial", rd, rows[i][15:4]);
      chk("stream", resultData, rows[i][15:4]);
      chk("mux", {7'h00, singleEnded, analog_input_zero_pos, analog_input_zero_neg, analog_input_one_pos,
        analog_input_one_neg}, {7'h00, rows[i][33], rows[i][3:0]});
      pop();
    end
    // Buffer fills, third word dropped
    conv(6'h02, 12'h111);
    conv(6'h02, 12'h222);
    conv(6'h02, 12'h333);
    chk("serial", rd, 12'h333);
    chk("first", resultData, 12'h111);
    pop();
    chk("second", resultData, 12'h222);
    pop();
    chk("empty", {11'h000, resultValid}, 12'h000);
    // Second edge in conversion, then long pulse into sleep
    n = holds;
    @(posedge clk) code <= 12'h5A5;
    host_inst.start(250);
    fork
      host_inst.start(2600);
      begin
        repeat (24) @(posedge clk);
        chk("asleep", {11'h000, poweredUp}, 12'h000);
        chk("oe high start", {11'h000, serialOutEn}, 12'h000);
      end
    join
    repeat (8) @(posedge clk);
    chk("awake", {11'h000, poweredUp}, 12'h001);
    chk("oe low start", {11'h000, serialOutEn}, 12'h001);
    host_inst.xfer(6'h02, rd);
    chk("serial", rd, 12'h5A5);
    chk("holds", 12'(holds - n), 12'h001);
    // Reset with a word pending
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("reset valid", {11'h000, resultValid}, 12'h000);
    chk("reset oe", {11'h000, serialOutEn}, 12'h000);
    chk("reset power", {11'h000, poweredUp}, 12'h001);
    end_sim();
  end
endmodule
bind sar_adc_convert_readout_ctrl sar_adc_monitor sar_adc_monitor_inst (.clk, .resetn, .conversion_start_pin,
  .serialClk, .serialOut, .serialOutEn, .sampleConnect, .sampleHold, .analog_input_zero_neg,
  .analog_input_one_neg, .singleEnded, .bitTrial, .poweredUp, .resultValid, .resultReady, .resultData);
`default_nettype wire
